// File: verilog/wwd_pkg.sv
package wwd_pkg;

   // Register indices; the byte address on the bus is four times the index
   localparam logic [7:0] IDX_CTRL_PERIOD = 8'h78;
   localparam logic [7:0] IDX_CTRL_CLOCK = 8'h79;
   localparam logic [7:0] IDX_PSC_LOW = 8'h7a;
   localparam logic [7:0] IDX_PSC_HIGH = 8'h7b;
   localparam logic [7:0] IDX_TIMER = 8'h7c;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h7d;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h7e;

   // Field positions
   localparam int SEN_BIT = 0;
   localparam int PERIOD_LSB = 1;
   localparam int WINDOW_LSB = 0;
   localparam int CLOCK_LSB = 4;
   localparam int ARMED_BIT = 2;
   localparam int TIMER_LSB = 3;
   localparam int IRQ_TIMEOUT_BIT = 0;
   localparam int IRQ_VIOLATION_BIT = 1;

   localparam int PSC_WIDTH = 18;
   localparam int TMR_WIDTH = 5;

   // Fuse values that leave a field writable, and reset values
   localparam logic [4:0] PERIOD_FUSE_FREE = 5'h1f;
   localparam logic [4:0] PERIOD_RESET = 5'h0b;
   localparam logic [4:0] PERIOD_MAX_CODE = 5'h12;
   localparam logic [2:0] CLOCK_FUSE_FREE = 3'h7;
   localparam logic [2:0] CLOCK_RESET = 3'h0;
   localparam logic [2:0] WINDOW_FUSE_FREE = 3'h7;
   localparam logic [2:0] WINDOW_FULL_OPEN = 3'h7;
   localparam logic [4:0] WINDOW_STEP = 5'h04;
   localparam logic [4:0] TMR_LAST = 5'h1f;
   localparam logic [1:0] IRQ_RESET = 2'h0;

   // Operating modes
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_SOFT = 2'h1;
   localparam logic [1:0] MODE_NO_SLEEP = 2'h2;
   localparam logic [1:0] MODE_ALWAYS = 2'h3;

   // Clock source codes
   localparam logic [2:0] CLK_LOW_FREQ_INT = 3'h0;
   localparam logic [2:0] CLK_MID_FREQ_INT = 3'h1;
   localparam logic [2:0] CLK_SECONDARY = 3'h2;
   localparam logic [2:0] CLK_EXTERNAL = 3'h3;

   // Start-up: fuses are loaded once their synchronisers have settled
   localparam logic [1:0] INIT_LOAD = 2'h2;
   localparam logic [1:0] INIT_DONE = 2'h3;

   // Reserved period codes fall back to the shortest interval
   function automatic logic [4:0] period_shift(input logic [4:0] code);
      return (code > PERIOD_MAX_CODE) ? 5'h00 : code;
   endfunction

   function automatic logic [PSC_WIDTH-1:0] psc_last(input logic [4:0] code);
      logic [PSC_WIDTH:0] span;
      span = (PSC_WIDTH+1)'(1) << period_shift(code);
      return PSC_WIDTH'(span - (PSC_WIDTH+1)'(1));
   endfunction

   function automatic logic window_closed(input logic [2:0] win,
                                          input logic [4:0] tmr);
      logic [4:0] limit;
      limit = 5'(5'(WINDOW_FULL_OPEN - win) * WINDOW_STEP);
      return tmr < limit;
   endfunction

endpackage

// File: verilog/wwd_sync.sv
`timescale 1ns/10ps
module wwd_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clock,              // System clock
   input wire logic rst_n,              // Synchronous-domain reset, low
   input wire logic [WIDTH-1:0] din,    // Asynchronous level
   output logic [WIDTH-1:0] dout        // Level after two flops
);
   logic [WIDTH-1:0] stage;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         stage <= '0;
         dout <= '0;
      end else begin
         stage <= din;
         dout <= stage;
      end
   end
endmodule

// File: verilog/wwd_top.sv
// Local design decision: register access over Avalon-MM.
`timescale 1ns/10ps
module wwd_top
   import wwd_pkg::*;
(
   input wire logic clock,                  // 200 MHz system clock
   input wire logic rst_n,                  // Asynchronous reset, low
   input wire logic [9:0] avs_address,      // Byte address
   input wire logic avs_read,               // Read request
   input wire logic avs_write,              // Write request
   input wire logic [31:0] avs_writedata,   // Write data
   input wire logic [3:0] avs_byteenable,   // Byte lanes
   output logic [31:0] avs_readdata,        // Read data
   output logic avs_waitrequest,            // Slave not ready
   input wire logic [1:0] cfg_watchdog_mode, // Mode fuse
   input wire logic [4:0] cfg_period_fuse,  // Period fuse
   input wire logic [2:0] cfg_clock_fuse,   // Clock-source fuse
   input wire logic [2:0] cfg_window_fuse,  // Window fuse
   input wire logic wdt_clk_in,             // Selected oscillator
   input wire logic device_sleep,           // Core is asleep
   input wire logic watchdog_clear_instr,   // Clear pulse from the core
   output logic [3:0] osc_enable,           // One-hot oscillator request, zero for reserved codes
   output logic watchdog_reset,             // Reset request pulse
   output logic irq                         // Interrupt, high level
);
   logic [1:0] rst_pipe, mode_sync, init_cnt, mode, irq_status, irq_mask;
   logic [4:0] period_fuse_sync, period_fuse, period_select;
   logic [2:0] clock_fuse_sync, window_fuse_sync, clock_fuse, window_fuse;
   logic [2:0] clock_source_field, window_select;
   logic [PSC_WIDTH-1:0] prescaler_count;
   logic [TMR_WIDTH-1:0] window_count_bits;
   logic [7:0] index, read_value;
   logic sys_rst_n, tick_sync, sleep_sync, tick_prev, sleep_prev, init_done;
   logic soft_enable, armed, bus_ack, wr_ack, rd_ack, ctrl_write;
   logic tick_edge, sleep_edge, wdt_active, windowed, clear_req, violation;
   logic timeout, timer_clear, psc_wrap;

   // Reset release through two flops
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign sys_rst_n = rst_pipe[1];

   wwd_sync #(.WIDTH(15)) u_sync_fuse (
      .clock(clock),
      .rst_n(sys_rst_n),
      .din({cfg_watchdog_mode, cfg_period_fuse, cfg_clock_fuse,
            cfg_window_fuse, wdt_clk_in, device_sleep}),
      .dout({mode_sync, period_fuse_sync, clock_fuse_sync,
             window_fuse_sync, tick_sync, sleep_sync})
   );

   always_ff @(posedge clock or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         tick_prev <= 1'b0;
         sleep_prev <= 1'b0;
      end else begin
         tick_prev <= tick_sync;
         sleep_prev <= sleep_sync;
      end
   end
   assign tick_edge = tick_sync && !tick_prev;
   assign sleep_edge = sleep_sync && !sleep_prev;

   // Fuses are caught once after release, then held as straps
   always_ff @(posedge clock or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         init_cnt <= 2'h0;
      end else if (init_cnt != INIT_DONE) begin
         init_cnt <= init_cnt + 2'h1;
      end
   end
   assign init_done = (init_cnt == INIT_DONE);

   always_ff @(posedge clock or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         mode <= MODE_OFF;
         period_fuse <= PERIOD_FUSE_FREE;
         clock_fuse <= CLOCK_FUSE_FREE;
         window_fuse <= WINDOW_FUSE_FREE;
      end else if (init_cnt == INIT_LOAD) begin
         mode <= mode_sync;
         period_fuse <= period_fuse_sync;
         clock_fuse <= clock_fuse_sync;
         window_fuse <= window_fuse_sync;
      end
   end

   // Bus slave: one cycle of waitrequest low per request; a write lands
   // only at the edge that completes the transfer, with waitrequest low
   assign index = avs_address[9:2];
   assign bus_ack = (avs_read || avs_write) && avs_waitrequest && init_done;
   assign wr_ack = avs_write && !avs_waitrequest && avs_byteenable[0];
   assign rd_ack = bus_ack && avs_read;
   assign ctrl_write = wr_ack &&
      (index == IDX_CTRL_PERIOD || index == IDX_CTRL_CLOCK);

   always_ff @(posedge clock or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !bus_ack;
      end
   end

   // Period and soft enable
   always_ff @(posedge clock or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         period_select <= PERIOD_RESET;
         soft_enable <= 1'b0;
      end else if (init_cnt == INIT_LOAD) begin
         period_select <= (period_fuse_sync == PERIOD_FUSE_FREE) ?
            PERIOD_RESET : period_fuse_sync;
      end else if (wr_ack && index == IDX_CTRL_PERIOD) begin
         if (period_fuse == PERIOD_FUSE_FREE) begin
            period_select <= avs_writedata[PERIOD_LSB +: 5];
         end
         soft_enable <= avs_writedata[SEN_BIT];
      end
   end

   // Clock source and window
   always_ff @(posedge clock or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         clock_source_field <= CLOCK_RESET;
         window_select <= WINDOW_FULL_OPEN;
      end else if (init_cnt == INIT_LOAD) begin
         clock_source_field <= (clock_fuse_sync == CLOCK_FUSE_FREE) ?
            CLOCK_RESET : clock_fuse_sync;
         window_select <= window_fuse_sync;
      end else if (wr_ack && index == IDX_CTRL_CLOCK) begin
         if (clock_fuse == CLOCK_FUSE_FREE) begin
            clock_source_field <= avs_writedata[CLOCK_LSB +: 3];
         end
         if (window_fuse == WINDOW_FUSE_FREE) begin
            window_select <= avs_writedata[WINDOW_LSB +: 3];
         end
      end
   end

   // Reserved codes request no oscillator, so the timer stalls visibly
   always_ff @(posedge clock or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         osc_enable <= 4'h0;
      end else begin
         unique case (clock_source_field)
            CLK_LOW_FREQ_INT: osc_enable <= 4'h1;
            CLK_MID_FREQ_INT: osc_enable <= 4'h2;
            CLK_SECONDARY: osc_enable <= 4'h4;
            CLK_EXTERNAL: osc_enable <= 4'h8;
            default: osc_enable <= 4'h0;
         endcase
      end
   end

   // Mode 10 stops in sleep; mode 01 follows soft enable
   always_comb begin
      unique case (mode)
         MODE_ALWAYS: wdt_active = 1'b1;
         MODE_NO_SLEEP: wdt_active = !sleep_sync;
         MODE_SOFT: wdt_active = soft_enable;
         MODE_OFF: wdt_active = 1'b0;
      endcase
   end

   assign windowed = (window_select != WINDOW_FULL_OPEN);
   assign clear_req = watchdog_clear_instr && init_done && wdt_active;
   assign violation = clear_req && windowed &&
      (!armed || window_closed(window_select, window_count_bits));
   assign psc_wrap = (prescaler_count >= psc_last(period_select));
   assign timeout = tick_edge && wdt_active && psc_wrap &&
      (window_count_bits == TMR_LAST);
   assign timer_clear = !init_done || !wdt_active || ctrl_write ||
      clear_req || sleep_edge || timeout;

   // Prescaler divides by 2**code, by 1 for a reserved code; the 5-bit timer by 32 more
   always_ff @(posedge clock or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         prescaler_count <= '0;
         window_count_bits <= '0;
      end else if (timer_clear) begin
         prescaler_count <= '0;
         window_count_bits <= '0;
      end else if (tick_edge) begin
         if (psc_wrap) begin
            prescaler_count <= '0;
            window_count_bits <= window_count_bits + 5'h01;
         end else begin
            prescaler_count <= prescaler_count + 18'h00001;
         end
      end
   end

   // Reading the period register arms, even in a cycle with a clear; any other clear disarms
   always_ff @(posedge clock or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         armed <= 1'b0;
      end else if (rd_ack && index == IDX_CTRL_PERIOD) begin
         armed <= 1'b1;
      end else if (clear_req || timer_clear) begin
         armed <= 1'b0;
      end
   end

   // Violation resets like a time-out
   always_ff @(posedge clock or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         watchdog_reset <= 1'b0;
      end else begin
         watchdog_reset <= timeout || violation;
      end
   end

   // Sticky events; a new event beats a same-cycle write of one
   always_ff @(posedge clock or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         irq_status <= IRQ_RESET;
      end else begin
         if (wr_ack && index == IDX_IRQ_STATUS) begin
            irq_status <= irq_status & ~avs_writedata[1:0] |
               {violation, timeout};
         end else begin
            irq_status <= irq_status | {violation, timeout};
         end
      end
   end

   always_ff @(posedge clock or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         irq_mask <= IRQ_RESET;
      end else if (wr_ack && index == IDX_IRQ_MASK) begin
         irq_mask <= avs_writedata[1:0];
      end
   end

   always_ff @(posedge clock or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_mask);
      end
   end

   always_comb begin
      read_value = 8'h00;
      unique case (index)
         IDX_CTRL_PERIOD: begin
            read_value[PERIOD_LSB +: 5] = period_select;
            read_value[SEN_BIT] = soft_enable;
         end
         IDX_CTRL_CLOCK: begin
            read_value[CLOCK_LSB +: 3] = clock_source_field;
            read_value[WINDOW_LSB +: 3] = window_select;
         end
         IDX_PSC_LOW: read_value = prescaler_count[7:0];
         IDX_PSC_HIGH: read_value = prescaler_count[15:8];
         IDX_TIMER: begin
            read_value[TIMER_LSB +: 5] = window_count_bits;
            read_value[ARMED_BIT] = armed;
            read_value[1:0] = prescaler_count[17:16];
         end
         IDX_IRQ_STATUS: read_value[1:0] = irq_status;
         IDX_IRQ_MASK: read_value[1:0] = irq_mask;
         default: read_value = 8'h00;
      endcase
   end

   always_ff @(posedge clock or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         avs_readdata <= 32'h00000000;
      end else if (rd_ack) begin
         avs_readdata <= {24'h000000, read_value};
      end
   end

   chk_min_prescale: assert property (
      @(posedge clock) disable iff (!sys_rst_n)
      tick_edge && !timer_clear && period_select > PERIOD_MAX_CODE
      |=> window_count_bits == $past(window_count_bits) + 5'h01)
      else $error("reserved period code did not act as minimum");

   chk_write_clears: assert property (
      @(posedge clock) disable iff (!sys_rst_n)
      ctrl_write |=> prescaler_count == '0 && window_count_bits == '0)
      else $error("control write did not clear timer");

   chk_period_locked: assert property (
      @(posedge clock) disable iff (!sys_rst_n)
      init_done && period_fuse != PERIOD_FUSE_FREE |=> $stable(period_select))
      else $error("locked period field changed");

   chk_clock_locked: assert property (
      @(posedge clock) disable iff (!sys_rst_n)
      init_done && clock_fuse != CLOCK_FUSE_FREE
      |=> $stable(clock_source_field))
      else $error("locked clock field changed");

   chk_window_locked: assert property (
      @(posedge clock) disable iff (!sys_rst_n)
      init_done && window_fuse != WINDOW_FUSE_FREE |=> $stable(window_select))
      else $error("locked window field changed");

   chk_disabled_cleared: assert property (
      @(posedge clock) disable iff (!sys_rst_n)
      init_done && mode == MODE_SOFT && !soft_enable
      |=> prescaler_count == '0 && window_count_bits == '0)
      else $error("software-disabled watchdog kept counting");

   chk_unarmed_clear: assert property (
      @(posedge clock) disable iff (!sys_rst_n)
      clear_req && windowed && !armed
      |=> watchdog_reset && irq_status[IRQ_VIOLATION_BIT])
      else $error("unarmed clear gave no violation");

   chk_closed_clear: assert property (
      @(posedge clock) disable iff (!sys_rst_n)
      clear_req && window_select == 3'h0 && window_count_bits < 5'h1c
      |=> watchdog_reset)
      else $error("clear in closed window gave no reset");

   chk_armed_read: assert property (
      @(posedge clock) disable iff (!sys_rst_n)
      rd_ack && index == IDX_TIMER
      |=> avs_readdata[ARMED_BIT] == $past(armed))
      else $error("armed flag read back wrong");

   chk_read_arms: assert property (
      @(posedge clock) disable iff (!sys_rst_n)
      rd_ack && index == IDX_CTRL_PERIOD
      |=> armed)
      else $error("reading period register did not arm");

   chk_psc_low: assert property (
      @(posedge clock) disable iff (!sys_rst_n)
      rd_ack && index == IDX_PSC_LOW
      |=> avs_readdata == {24'h000000, $past(prescaler_count[7:0])})
      else $error("prescaler low byte read back wrong");

   chk_unmapped_zero: assert property (
      @(posedge clock) disable iff (!sys_rst_n)
      rd_ack && (index < IDX_CTRL_PERIOD || index > IDX_IRQ_MASK)
      |=> avs_readdata == 32'h00000000 && !avs_waitrequest)
      else $error("unmapped read not zero");

endmodule

// File: sim/wwd_top_bench.sv
`timescale 1ns/10ps
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin \
   n_mismatch++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), \
   (exp)); end end

module wwd_top_bench;
   import wwd_pkg::*;
   logic clock, rst_n, avs_read, avs_write, avs_waitrequest, wdt_clk_in;
   logic watchdog_clear_instr, watchdog_reset, irq, m_armed, m_active;
   logic [9:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd, seed;
   logic [3:0] avs_byteenable, osc_enable;
   logic [1:0] cfg_watchdog_mode;
   logic [4:0] cfg_period_fuse;
   logic [2:0] cfg_clock_fuse, cfg_window_fuse;
   int n_mismatch, samples_checked, n_resets, m_resets, m_edges, m_shift;
   int m_status, thr;
   int codes[6] = '{0, 1, 2, 3, 19, 31};
   int wins[3] = '{6, 0, 3};

   wwd_top i_wwd_top (
      .clock(clock), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .cfg_watchdog_mode(cfg_watchdog_mode),
      .cfg_period_fuse(cfg_period_fuse), .cfg_clock_fuse(cfg_clock_fuse),
      .cfg_window_fuse(cfg_window_fuse), .wdt_clk_in(wdt_clk_in),
      .device_sleep(1'b0), .watchdog_clear_instr(watchdog_clear_instr),
      .osc_enable(osc_enable), .watchdog_reset(watchdog_reset), .irq(irq)
   );

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // Count every reset request the block issues
   always @(posedge clock) begin
      if (watchdog_reset === 1'b1) n_resets <= n_resets + 1;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic complete_run;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [7:0] idx,
                      input logic [31:0] wd, input logic [3:0] be);
      @(posedge clock);
      avs_address <= {idx, 2'b00};
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= wd;
      avs_byteenable <= be;
      do begin
         @(posedge clock);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      bus(1'b1, idx, d, 4'hf);
   endtask

   task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 32'h0, 4'hf);
      `CHECK(rd, exp)
   endtask

   // Slow oscillator edges; the tail lets the synchroniser settle
   task automatic pulses(input int cnt);
      repeat (cnt) begin
         @(posedge clock) wdt_clk_in <= 1'b1;
         repeat (4) @(posedge clock);
         wdt_clk_in <= 1'b0;
         repeat (4) @(posedge clock);
      end
      repeat (8) @(posedge clock);
      if (m_active) m_edges += cnt;
   endtask

   task automatic counts;
      int psc, tmr;
      psc = m_edges % (1 << m_shift);
      tmr = m_edges >> m_shift;
      rd_chk(IDX_PSC_LOW, 32'(psc[7:0]));
      rd_chk(IDX_PSC_HIGH, 32'(psc[15:8]));
      rd_chk(IDX_TIMER, 32'({tmr[4:0], m_armed, psc[17:16]}));
      rd_chk(IDX_IRQ_STATUS, 32'(m_status));
      `CHECK(irq, (m_status != 0))
   endtask

   task automatic clear_chk(input logic bad);
      @(posedge clock) watchdog_clear_instr <= 1'b1;
      @(posedge clock) watchdog_clear_instr <= 1'b0;
      repeat (4) @(posedge clock);
      if (bad) begin
         m_resets++;
         m_status |= 2;
      end
      m_edges = 0;
      m_armed = 1'b0;
      `CHECK(n_resets, m_resets)
      counts;
   endtask

   task automatic do_reset(input logic [1:0] md, input logic [4:0] pf,
                           input logic [2:0] cf, input logic [2:0] wf);
      cfg_watchdog_mode <= md;
      cfg_period_fuse <= pf;
      cfg_clock_fuse <= cf;
      cfg_window_fuse <= wf;
      rst_n <= 1'b0;
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      repeat (10) @(posedge clock);
      m_edges = 0;
      m_armed = 1'b0;
      m_active = 1'b0;
      m_status = 0;
      m_resets = n_resets;
      m_shift = (pf == 5'h1f) ? 11 : int'(pf);
   endtask

   initial begin
      repeat (30000) @(posedge clock);
      n_mismatch++;
      complete_run;
   end

   initial begin
      rst_n = 1'b0;
      avs_address = 10'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
      wdt_clk_in = 1'b0;
      watchdog_clear_instr = 1'b0;
      cfg_watchdog_mode = 2'h1;
      cfg_period_fuse = 5'h1f;
      cfg_clock_fuse = 3'h7;
      cfg_window_fuse = 3'h7;
      seed = 32'hd8ab;
      do_reset(2'h1, 5'h1f, 3'h7, 3'h7);
      rd_chk(IDX_CTRL_PERIOD, 32'h16);
      rd_chk(IDX_CTRL_CLOCK, 32'h07);
      rd_chk(IDX_IRQ_MASK, 32'h0);
      `CHECK(osc_enable, 4'h1)
      wr(IDX_IRQ_MASK, 32'h3);
      pulses(3);
      counts;
      for (int c = 0; c < 8; c++) begin
         wr(IDX_CTRL_CLOCK, 32'(c * 16 + 7));
         rd_chk(IDX_CTRL_CLOCK, 32'(c * 16 + 7));
         `CHECK(osc_enable, (c < 4) ? 4'(1 << c) : 4'h0)
      end
      wr(IDX_CTRL_CLOCK, 32'h07);
      wr(IDX_CTRL_PERIOD, 32'hffffffff);
      m_active = 1'b1;
      rd_chk(IDX_CTRL_PERIOD, 32'h3f);
      // Each period write clears the counts, so the model restarts
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         wr(IDX_CTRL_PERIOD, {seed[31:6], 5'(codes[i]), 1'b1});
         m_edges = 0;
         m_armed = 1'b0;
         m_shift = (codes[i] > 18) ? 0 : codes[i];
         pulses(1 + int'(seed[3:0]) % 12);
         counts;
         wr(IDX_CTRL_CLOCK, 32'h07);
         m_edges = 0;
         counts;
      end
      pulses(31);
      counts;
      pulses(1);
      m_resets++;
      m_status |= 1;
      m_edges = 0;
      `CHECK(n_resets, m_resets)
      counts;
      wr(IDX_IRQ_STATUS, 32'h1);
      m_status = 0;
      counts;
      for (int i = 0; i < 3; i++) begin
         wr(IDX_CTRL_CLOCK, 32'(wins[i]));
         thr = (7 - wins[i]) * 4;
         m_edges = 0;
         m_armed = 1'b0;
         pulses(thr);
         clear_chk(1'b1);
         rd_chk(IDX_CTRL_PERIOD, 32'h3f);
         m_armed = 1'b1;
         pulses(thr - 1);
         clear_chk(1'b1);
         rd_chk(IDX_CTRL_PERIOD, 32'h3f);
         m_armed = 1'b1;
         pulses(thr);
         counts;
         clear_chk(1'b0);
      end
      wr(IDX_IRQ_STATUS, 32'h3);
      m_status = 0;
      counts;
      wr(8'h10, 32'hff);
      rd_chk(8'h10, 32'h0);
      bus(1'b1, IDX_CTRL_CLOCK, 32'h05, 4'he);
      rd_chk(IDX_CTRL_CLOCK, 32'h03);
      do_reset(2'h0, 5'h05, 3'h2, 3'h3);
      rd_chk(IDX_CTRL_PERIOD, 32'h0a);
      rd_chk(IDX_CTRL_CLOCK, 32'h23);
      `CHECK(osc_enable, 4'h4)
      wr(IDX_CTRL_PERIOD, 32'hff);
      wr(IDX_CTRL_CLOCK, 32'hff);
      rd_chk(IDX_CTRL_PERIOD, 32'h0b);
      rd_chk(IDX_CTRL_CLOCK, 32'h23);
      pulses(3);
      counts;
      // Awake-only and always-on modes count with soft enable low
      for (int m = 2; m < 4; m++) begin
         do_reset(2'(m), 5'h00, 3'h7, 3'h7);
         m_active = 1'b1;
         pulses(3);
         counts;
      end
      complete_run;
   end
endmodule
